// ==== rsp_pkg.sv ====
// Shared constants and types for the clock-chip two-wire slave port.
// Assumes the importing modules run on one system clock with async reset.
package rsp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus addresses and byte layout
	localparam logic [7:0] RSP_ADDR_WR   = 8'hac;
	localparam logic [7:0] RSP_ADDR_RD   = 8'had;
	localparam int         RSP_BYTE_BITS = 8;
	localparam logic [3:0] RSP_BIT_LAST  = 4'h8;
	localparam int         RSP_WORD_BITS = 3;
	localparam int         RSP_PAGE_LSB  = 3;
	localparam int         RSP_DIR_BIT   = 0;
	localparam logic [7:0] RSP_LOC_RESET = 8'h00;

	// Number of pages mirrored in the cache
	localparam int RSP_CACHE_PAGES = 8;
	localparam int RSP_PAGE_WORDS  = 8;

	////////////////////////////////////////////////////////////////////////
	// Protocol states and byte roles
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_RX    = 5'b00010,
		S_ACKTX = 5'b00100,
		S_TX    = 5'b01000,
		S_ACKRX = 5'b10000
	} rsp_state_t;

	typedef enum logic [2:0] {
		ROLE_ADDR = 3'b001,
		ROLE_LOC  = 3'b010,
		ROLE_DATA = 3'b100
	} rsp_role_t;

	// Next location: word part wraps, page part is kept
	function automatic logic [7:0] rsp_next_loc(input logic [7:0] loc);
		logic [RSP_WORD_BITS-1:0] w;
		w = loc[RSP_WORD_BITS-1:0] + 3'h1;
		return {loc[7:RSP_PAGE_LSB], w};
	endfunction

endpackage

// ==== rsp_line_sync.sv ====
// Line conditioner: synchronises the clock and data wires and finds
// edges plus start and stop conditions on the system clock.
// Assumes the wire clock is far slower than the system clock.
`timescale 1ns/10ps
module rsp_line_sync
	import rsp_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic reset_n_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_hi_out,
	output logic      sda_hi_out,
	output logic      scl_rise_out,
	output logic      scl_fall_out,
	output logic      start_out,
	output logic      stop_out
);

	logic [2:0] scl_q;
	logic [2:0] scl_d;
	logic [2:0] sda_q;
	logic [2:0] sda_d;

	////////////////////////////////////////////////////////////////////////
	// Two flops of synchronisation, third flop only for edge finding
	always_comb begin
		scl_d = {scl_q[1:0], scl_in};
		sda_d = {sda_q[1:0], sda_in};
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end

	// Edges and conditions read stages two and three only
	always_comb begin
		scl_hi_out   = scl_q[1];
		sda_hi_out   = sda_q[1];
		scl_rise_out = scl_q[1] & ~scl_q[2];
		scl_fall_out = ~scl_q[1] & scl_q[2];
		start_out    = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
		stop_out     = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_start_seen;
		@(posedge mclk_in) disable iff (!reset_n_in)
		(scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1]) |-> start_out && !stop_out;
	endproperty
	a_start_seen: assert property (p_start_seen) else $error("start missed");

endmodule

// ==== rsp_slave_port.sv ====
// Two-wire slave port of the clock chip, with a snapshot cache of the
// timekeeping registers and write-back after a write transfer closed by stop.
// Assumes live registers arrive as one flat bus, written back by strobe.
`timescale 1ns/10ps
module rsp_slave_port
	import rsp_pkg::*;
#(
	parameter int CACHE_PAGES = RSP_CACHE_PAGES
)(
	input  wire logic                                mclk_in,
	input  wire logic                                reset_n_in,
	input  wire logic                                scl_in,
	input  wire logic                                sda_in,
	output logic                                     sda_out,
	output logic                                     sda_oe_out,
	input  wire logic [CACHE_PAGES*RSP_PAGE_WORDS*8-1:0] live_regs_in,
	output logic                                     reg_wr_en_out,
	output logic [7:0]                               reg_wr_addr_out,
	output logic [7:0]                               reg_wr_data_out,
	output logic                                     busy_out
);

	localparam int CW = CACHE_PAGES * RSP_PAGE_WORDS;
	localparam int IW = $clog2(CW);
	localparam logic [IW-1:0] IDX_LAST = IW'(CW - 1);

	// All checks below run on the system clock and rest during reset
	default clocking cb_chk @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	logic scl_hi;
	logic sda_hi;
	logic scl_rise;
	logic scl_fall;
	logic start_p;
	logic stop_p;

	////////////////////////////////////////////////////////////////////////
	// Wire conditioning
	rsp_line_sync u_sync (
		.mclk_in      (mclk_in),
		.reset_n_in   (reset_n_in),
		.scl_in       (scl_in),
		.sda_in       (sda_in),
		.scl_hi_out   (scl_hi),
		.sda_hi_out   (sda_hi),
		.scl_rise_out (scl_rise),
		.scl_fall_out (scl_fall),
		.start_out    (start_p),
		.stop_out     (stop_p)
	);

	////////////////////////////////////////////////////////////////////////
	// Protocol state
	rsp_state_t st_q, st_d;
	rsp_role_t  role_q, role_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] loc_q, loc_d;
	logic       rd_q, rd_d;
	logic       wrx_q, wrx_d;
	logic       oe_q, oe_d;
	logic       busy_q, busy_d;
	logic       sda_o_q;
	logic       wr_stb;
	logic       inc;
	logic       nack;
	logic [7:0] rd_byte;

	// Cache and write-back state
	logic [7:0]    cache_q [CW];
	logic [7:0]    cache_d [CW];
	logic [CW-1:0] dirty_q, dirty_d;
	logic          in_cache;
	logic [IW-1:0] loc_idx;
	logic          wb_act_q, wb_act_d;
	logic [IW-1:0] wb_idx_q, wb_idx_d;
	logic          wb_stb;
	logic          wen_q, wen_d;
	logic [7:0]    waddr_q, waddr_d;
	logic [7:0]    wdata_q, wdata_d;

	// Locations beyond the mirrored pages read zero and drop writes
	always_comb begin
		in_cache = 32'(loc_q) < CW;
		loc_idx  = loc_q[IW-1:0];
		rd_byte  = in_cache ? cache_q[loc_idx] : 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Byte engine: only reacts to start, stop and clock edges the master makes
	always_comb begin
		st_d   = st_q;
		role_d = role_q;
		bit_d  = bit_q;
		sh_d   = sh_q;
		loc_d  = loc_q;
		rd_d   = rd_q;
		wrx_d  = wrx_q;
		oe_d   = oe_q;
		busy_d = busy_q;
		wr_stb = 1'b0;
		inc    = 1'b0;
		nack   = 1'b0;
		if (stop_p) begin
			// Stop aborts anything and releases the wire
			st_d   = S_IDLE;
			oe_d   = 1'b0;
			busy_d = 1'b0;
			wrx_d  = 1'b0;
		end else if (start_p) begin
			// A start mid-transfer restarts decoding rather than hanging
			st_d   = S_RX;
			role_d = ROLE_ADDR;
			bit_d  = 4'h0;
			oe_d   = 1'b0;
			busy_d = 1'b1;
			rd_d   = 1'b0;
			wrx_d  = 1'b0;
		end else begin
			unique case (st_q)
				S_IDLE: begin
				end
				S_RX: begin
					if (scl_rise && bit_q != RSP_BIT_LAST) begin
						sh_d  = {sh_q[6:0], sda_hi};
						bit_d = bit_q + 4'h1;
					end else if (scl_fall && bit_q == RSP_BIT_LAST) begin
						bit_d = 4'h0;
						st_d  = S_ACKTX;
						oe_d  = 1'b1;
						unique case (role_q)
							ROLE_ADDR: begin
								if (sh_q == RSP_ADDR_WR || sh_q == RSP_ADDR_RD) begin
									rd_d  = sh_q[RSP_DIR_BIT];
									wrx_d = ~sh_q[RSP_DIR_BIT];
								end else begin
									st_d   = S_IDLE;
									oe_d   = 1'b0;
									busy_d = 1'b0;
								end
							end
							ROLE_LOC: begin
								loc_d = sh_q;
							end
							ROLE_DATA: begin
								wr_stb = 1'b1;
								inc    = 1'b1;
							end
						endcase
					end
				end
				S_ACKTX: begin
					if (scl_fall) begin
						if (rd_q) begin
							// First bit leaves on the fall that ends acknowledge
							sh_d  = rd_byte;
							oe_d  = ~rd_byte[7];
							bit_d = 4'h1;
							st_d  = S_TX;
						end else begin
							oe_d   = 1'b0;
							st_d   = S_RX;
							role_d = (role_q == ROLE_ADDR) ? ROLE_LOC : ROLE_DATA;
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (bit_q == RSP_BIT_LAST) begin
							oe_d = 1'b0;
							st_d = S_ACKRX;
						end else begin
							sh_d  = {sh_q[6:0], 1'b0};
							oe_d  = ~sh_q[6];
							bit_d = bit_q + 4'h1;
						end
					end
				end
				S_ACKRX: begin
					if (scl_rise) begin
						if (!sda_hi) begin
							inc  = 1'b1;
							st_d = S_ACKTX;
						end else begin
							nack   = 1'b1;
							st_d   = S_IDLE;
							busy_d = 1'b0;
						end
					end
				end
			endcase
		end
		if (inc) begin
			loc_d = rsp_next_loc(loc_q);
		end
	end

	// Protocol registers; data output is always low, only enable moves
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_q    <= S_IDLE;
			role_q  <= ROLE_ADDR;
			bit_q   <= 4'h0;
			sh_q    <= 8'h00;
			loc_q   <= RSP_LOC_RESET;
			rd_q    <= 1'b0;
			wrx_q   <= 1'b0;
			oe_q    <= 1'b0;
			busy_q  <= 1'b0;
			sda_o_q <= 1'b0;
		end else begin
			st_q    <= st_d;
			role_q  <= role_d;
			bit_q   <= bit_d;
			sh_q    <= sh_d;
			loc_q   <= loc_d;
			rd_q    <= rd_d;
			wrx_q   <= wrx_d;
			oe_q    <= oe_d;
			busy_q  <= busy_d;
			sda_o_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cache: snapshot on start, frozen otherwise except master writes
	always_comb begin
		cache_d = cache_q;
		dirty_d = dirty_q;
		if (start_p) begin
			// Entries still waiting for write-back keep their new value
			for (int i = 0; i < CW; i++) begin
				if (!dirty_q[i]) begin
					cache_d[i] = live_regs_in[i*8 +: 8];
				end
			end
		end
		if (wb_stb) begin
			dirty_d[wb_idx_q] = 1'b0;
		end
		// Set after clear so a write in the same cycle is not lost
		if (wr_stb && in_cache) begin
			cache_d[loc_idx] = sh_q;
			dirty_d[loc_idx] = 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < CW; i++) begin
				cache_q[i] <= 8'h00;
			end
			dirty_q <= '0;
		end else begin
			cache_q <= cache_d;
			dirty_q <= dirty_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write-back walker: one entry per cycle after a write transfer closed by stop
	always_comb begin
		wb_act_d = wb_act_q;
		wb_idx_d = wb_idx_q;
		wb_stb   = wb_act_q & dirty_q[wb_idx_q];
		wen_d    = wb_stb;
		waddr_d  = waddr_q;
		wdata_d  = wdata_q;
		if (wb_stb) begin
			waddr_d = 8'(wb_idx_q);
			wdata_d = cache_q[wb_idx_q];
		end
		if (wb_act_q) begin
			wb_idx_d = wb_idx_q + 1'b1;
			if (wb_idx_q == IDX_LAST) begin
				wb_act_d = 1'b0;
			end
		end
		if (stop_p && wrx_q) begin
			wb_act_d = 1'b1;
			wb_idx_d = '0;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wb_act_q <= 1'b0;
			wb_idx_q <= '0;
			wen_q    <= 1'b0;
			waddr_q  <= 8'h00;
			wdata_q  <= 8'h00;
		end else begin
			wb_act_q <= wb_act_d;
			wb_idx_q <= wb_idx_d;
			wen_q    <= wen_d;
			waddr_q  <= waddr_d;
			wdata_q  <= wdata_d;
		end
	end

	// Outputs straight from flops
	always_comb begin
		sda_out         = sda_o_q;
		sda_oe_out      = oe_q;
		reg_wr_en_out   = wen_q;
		reg_wr_addr_out = waddr_q;
		reg_wr_data_out = wdata_q;
		busy_out        = busy_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [CW*8-1:0] cache_flat;
	always_comb begin
		for (int i = 0; i < CW; i++) begin
			cache_flat[i*8 +: 8] = cache_q[i];
		end
	end

	property p_never_high; sda_out == 1'b0; endproperty
	a_never_high: assert property (p_never_high) else $error("data driven high");
	property p_ack_held; (st_q == S_ACKTX && !rd_q && scl_hi) |-> sda_oe_out; endproperty
	a_ack_held: assert property (p_ack_held) else $error("ack not held low");
	property p_stop_idle; stop_p |=> (st_q == S_IDLE) && !sda_oe_out && !busy_out; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");
	property p_nack_release;
		(st_q == S_ACKRX && scl_rise && sda_hi && !start_p && !stop_p)
			|=> !sda_oe_out && st_q == S_IDLE && $stable(loc_q);
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("nack mishandled");
	property p_foreign_addr;
		(st_q == S_RX && role_q == ROLE_ADDR && scl_fall && bit_q == RSP_BIT_LAST
			&& sh_q != RSP_ADDR_WR && sh_q != RSP_ADDR_RD && !start_p && !stop_p)
			|=> st_q == S_IDLE ##1 !sda_oe_out;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked");
	property p_wrap;
		inc |=> loc_q[7:3] == $past(loc_q[7:3]) && loc_q[2:0] == $past(loc_q[2:0]) + 3'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("word address step wrong");
	property p_frozen; (!start_p && !wr_stb) |=> $stable(cache_flat); endproperty
	a_frozen: assert property (p_frozen) else $error("cache changed mid transfer");
	property p_snapshot;
		(start_p && !dirty_q[0]) |=> cache_q[0] == $past(live_regs_in[7:0]);
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("snapshot missed");
	property p_writeback;
		(wb_act_q && dirty_q[wb_idx_q]) |=> reg_wr_en_out
			&& reg_wr_addr_out == 8'($past(wb_idx_q)) && !dirty_q[$past(wb_idx_q)];
	endproperty
	a_writeback: assert property (p_writeback) else $error("dirty entry not written");
	property p_clean_quiet; !(wb_act_q && dirty_q[wb_idx_q]) |=> !reg_wr_en_out; endproperty
	a_clean_quiet: assert property (p_clean_quiet) else $error("clean entry written");

endmodule

// ==== rsp_bus_master.sv ====
// Behavioural two-wire bus master driving the slave port's wires.
// Assumes an external pull-up on the data wire; the clock is pushed.
`timescale 1ns/10ps
module rsp_bus_master (
	input  wire logic mclk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	// Idle bus: both lines high
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Steps are 2+3 system cycles in the low phase and 1+4 in the high phase, so each clock phase is 5 cycles
	task automatic wait_q(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	// One clock pulse; line level sampled early and late in the high phase
	task automatic pulse(input logic bit_v, output logic s0, output logic s1);
		wait_q(2);
		sda_low_out = ~bit_v;
		wait_q(3);
		scl_out = 1'b1;
		wait_q(1);
		s0 = sda_in;
		wait_q(4);
		s1 = sda_in;
		scl_out = 1'b0;
	endtask

	// Start only from an idle bus
	task automatic start_c();
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		wait_q(5);
		sda_low_out = 1'b1;
		wait_q(5);
		scl_out = 1'b0;
	endtask

	// Every transfer closes with stop, so no repeated start is issued
	task automatic stop_c();
		wait_q(2);
		sda_low_out = 1'b1;
		wait_q(3);
		scl_out = 1'b1;
		wait_q(5);
		sda_low_out = 1'b0;
		wait_q(5);
	endtask

	// Byte out, then a ninth clock with the line released for the ack
	task automatic wr_byte(input logic [7:0] b, output logic acked);
		logic s0, s1;
		for (int i = 7; i >= 0; i--) pulse(b[i], s0, s1);
		pulse(1'b1, s0, s1);
		acked = ~s0 & ~s1;
	endtask

	// Byte in; ack low, or released on the last byte
	task automatic rd_byte(input logic ack, output logic [7:0] b, output logic steady);
		logic s0, s1;
		steady = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, s0, s1);
			b[i] = s0;
			steady = steady & (s0 == s1);
		end
		pulse(~ack, s0, s1);
	endtask
endmodule

// ==== rsp_slave_port_tb.sv ====
// Self-checking bench for the slave port against a bus master model.
// Assumes the live registers follow every write-back pulse.
`timescale 1ns/10ps
module rsp_slave_port_tb;
	import rsp_pkg::*;
	localparam int CW = RSP_CACHE_PAGES * RSP_PAGE_WORDS;
	logic            mclk_in, reset_n_in, scl, m_low;
	logic            sda_out, sda_oe_out, reg_wr_en_out, busy_out;
	logic [CW*8-1:0] live_regs_in;
	logic [7:0]      reg_wr_addr_out, reg_wr_data_out;
	logic [7:0]      live [CW];
	logic [15:0]     wb_q [$];
	int              num_errors, samples_checked, cycles;
	wire             sda_w = ~(m_low | (sda_oe_out & ~sda_out)); // pull-up

	rsp_slave_port #(.CACHE_PAGES(RSP_CACHE_PAGES)) u_rsp_slave_port (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_out(sda_oe_out), .live_regs_in(live_regs_in),
		.reg_wr_en_out(reg_wr_en_out), .reg_wr_addr_out(reg_wr_addr_out),
		.reg_wr_data_out(reg_wr_data_out), .busy_out(busy_out));
	rsp_bus_master u_rsp_bus_master (
		.mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl), .sda_low_out(m_low));

	////////////////////////////////////////////////////////////////////
	// Clock, live register image and write-back capture
	initial mclk_in = 1'b0;
	always #2.5 mclk_in = ~mclk_in;

	always_comb begin
		for (int i = 0; i < CW; i++) live_regs_in[i*8+:8] = live[i];
	end

	// Sampled off the rising edge so the pulse is settled
	always @(negedge mclk_in) begin
		if (reg_wr_en_out === 1'b1) begin
			live[reg_wr_addr_out] = reg_wr_data_out;
			wb_q.push_back({reg_wr_addr_out, reg_wr_data_out});
		end
	end

	// Hang guard: about nine times the expected run
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic send(input logic [7:0] b, input logic exp_ack);
		logic a;
		u_rsp_bus_master.wr_byte(b, a);
		check(16'(a), 16'(exp_ack));
	endtask

	task automatic recv(input logic ack, input logic [7:0] exp);
		logic [7:0] b;
		logic       st;
		u_rsp_bus_master.rd_byte(ack, b, st);
		check(16'(b), 16'(exp));
		check(16'(st), 16'h1);
	endtask

	task automatic sta();
		u_rsp_bus_master.start_c();
	endtask

	task automatic sto();
		u_rsp_bus_master.stop_c();
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_write();
		wb_q.delete();
		sta();
		send(RSP_ADDR_WR, 1'b1);
		check(16'(busy_out), 16'h1);
		send(8'h0e, 1'b1);
		send(8'ha1, 1'b1);
		send(8'ha2, 1'b1);
		send(8'ha3, 1'b1);
		sto();
		repeat (100) @(negedge mclk_in);
		check(16'(wb_q.size()), 16'h3);
		check(wb_q[0], 16'h08a3);
		check(wb_q[1], 16'h0ea1);
		check(wb_q[2], 16'h0fa2);
		$display("done write with wrap");
	endtask

	task automatic t_read_loc();
		wb_q.delete();
		sta();
		send(RSP_ADDR_WR, 1'b1);
		send(8'h0f, 1'b1);
		sto();
		sta();
		send(RSP_ADDR_RD, 1'b1);
		recv(1'b1, 8'ha2);
		recv(1'b0, 8'ha3);
		repeat (4) @(negedge mclk_in);
		check(16'(sda_oe_out), 16'h0);
		sto();
		repeat (100) @(negedge mclk_in);
		check(16'(wb_q.size()), 16'h0);
		$display("done located read");
	endtask

	task automatic t_nack_cont();
		sta();
		send(RSP_ADDR_RD, 1'b1);
		recv(1'b1, 8'ha3);
		recv(1'b1, live[9]);
		recv(1'b0, live[10]);
		sto();
		$display("done continued read");
	endtask

	task automatic t_snapshot();
		live[10] = 8'h3c;
		sta();
		live[10] = 8'hc3;
		send(RSP_ADDR_RD, 1'b1);
		recv(1'b0, 8'h3c);
		sto();
		sta();
		send(RSP_ADDR_RD, 1'b1);
		recv(1'b0, 8'hc3);
		sto();
		$display("done snapshot");
	endtask

	task automatic t_foreign();
		sta();
		send(8'ha4, 1'b0);
		check(16'(busy_out), 16'h0);
		send(8'h00, 1'b0);
		sto();
		check(16'(sda_out), 16'h0);
		$display("done foreign address");
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		reset_n_in = 1'b0;
		for (int i = 0; i < CW; i++) live[i] = 8'(i) ^ 8'h5a;
		repeat (20) @(negedge mclk_in);
		reset_n_in = 1'b1;
		repeat (5) @(negedge mclk_in);
		check(16'(sda_oe_out), 16'h0);
		t_write();
		t_read_loc();
		t_nack_cont();
		t_snapshot();
		t_foreign();
		stop_test();
	end
endmodule
